// ===== src/scms_defs.vh
// Constants for the serializer clock-mode select block.
// Assumes a register port with byte address and 8-bit data on the system clock.
// Notes on behaviour
// - Output-enabled pins may drive remote back-channel values, chosen via local pin data.
// - Synchronous mode, 50 Mbps back channel: sample pins at 1670 kHz, signals <=416 kHz.
// - Parallel-video mode, 2.5 Mbps: sample at 83.5 kHz, pin signals up to 20 kHz.
// - Mode is latched from the strap when power-down pin rises.
// - Forward rate follows reference; synchronous uses back-channel reference 23-26 MHz, f x 160.
// - External clock mode: divider code 000 gives f x 80, 001 gives f x 40.
// - Internal mode uses the always-on oscillator and disables the sensor reference clock.
// - Oscillator select 1 picks full-rate oscillator, 0 picks half-rate.
// - Sensor clock equals forward rate over high-speed divider times M/N; default 4.
// - Mode field always shows active mode; read-only while override bit 4 is 0.
// - With override set, software writes mode; 101 selects parallel-video external clock.
// - Parallel-video external clock mode runs forward rate at f x 28.
// - Back-channel mode register lets software force parallel-video 10-bit or 12-bit raw; here it is only stored and read back.
// - Parallel-video configuration register selects long, YUV and typed packet handling; only bit 7, type matching, reaches an output.
// - With type matching enabled, matching data types pass regardless of raw setting; this block filters nothing, it only outputs the enable and pv_dt.
`ifndef SCMS_DEFS_VH
`define SCMS_DEFS_VH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SCMS_ADDR_MODE 8'h03
`define SCMS_ADDR_BCMODE 8'h04
`define SCMS_ADDR_CLKCFG 8'h05
`define SCMS_ADDR_HSDIV 8'h06
`define SCMS_ADDR_LOCAL 8'h0d
`define SCMS_ADDR_PINCTL 8'h0e
`define SCMS_ADDR_PVCFG 8'h10
`define SCMS_ADDR_PVDT 8'h11
// ----------------------------------------
// Fields and codes
// ----------------------------------------
`define SCMS_OVR_BIT 4
`define SCMS_OSC_BIT 3
`define SCMS_MATCH_BIT 7
`define SCMS_MODE_SYNC 3'h0
`define SCMS_MODE_NSEXT 3'h2
`define SCMS_MODE_NSINT 3'h3
`define SCMS_MODE_PVEXT 3'h5
`define SCMS_DIV_X80 3'h0
`define SCMS_DIV_X40 3'h1
`define SCMS_MULT_SYNC 8'ha0
`define SCMS_MULT_X80 8'h50
`define SCMS_MULT_X40 8'h28
`define SCMS_MULT_PV 8'h1c
`define SCMS_HSDIV_RST 5'h04
`define SCMS_CLKCFG_RST 8'h08
`define SCMS_PINCTL_RST 8'h0f
// ----------------------------------------
// Back-channel sample timing (kHz, at 100 MHz)
// ----------------------------------------
`define SCMS_CLK_KHZ 100000
`define SCMS_SYNC_KHZ 1670
`define SCMS_NSYNC_KHZ 334
`define SCMS_PV_KHZ 83.5
// Sample periods in system clocks: clock rate over sample rate, rounded down
`define SCMS_CNT_SYNC 11'h03b
`define SCMS_CNT_NSYNC 11'h12b
`define SCMS_CNT_PV 11'h4ad
`endif

// ===== src/scms_clock_mode.v
// Clock-mode select, reference derivation and back-channel pin output path.
// Assumes a byte register port on i_sys_clk; strap and power-down pin are asynchronous.
`timescale 1ns/1ps
`include "scms_defs.vh"
module scms_clock_mode (
  // Clock and reset
  input wire i_sys_clk,
  input wire i_rst,
  // Pins from outside
  input wire [2:0] i_mode_strap,
  input wire i_power_down_pin,
  // Back channel pin values
  input wire [3:0] i_remote_pin,
  // Register port
  input wire i_reg_wr,
  input wire [7:0] i_reg_addr,
  input wire [7:0] i_reg_wdata,
  output reg [7:0] o_reg_rdata,
  // Pin outputs
  output reg [3:0] o_pin_out,
  output reg [3:0] o_pin_oe,
  // Clocking status
  output reg [1:0] o_ref_source,
  output reg [7:0] o_fc_multiplier,
  output reg [4:0] o_high_speed_divider,
  output reg o_sensor_clk_en,
  output reg o_parallel_video_mode,
  output reg o_type_match_enable,
  output reg [7:0] o_parallel_video_type_filter
);

  // ----------------------------------------
  // Synchronisers
  // ----------------------------------------
  // Two flops on every pin input, plus a third on power-down for edge detect; the first flop feeds no logic
  // The power-down flops clear low, so a pin already high at reset release
  // reads as one rising edge and latches the strap, as at power-up
  reg [2:0] strap_s1;
  reg [2:0] strap_s2;
  reg pdb_s1;
  reg pdb_s2;
  reg pdb_d;
  reg [3:0] remote_s1;
  reg [3:0] remote_s2;

  always @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      strap_s1 <= 3'h0;
      strap_s2 <= 3'h0;
      pdb_s1 <= 1'b0;
      pdb_s2 <= 1'b0;
      pdb_d <= 1'b0;
      remote_s1 <= 4'h0;
      remote_s2 <= 4'h0;
    end
    else
    begin
      strap_s1 <= i_mode_strap;
      strap_s2 <= strap_s1;
      pdb_s1 <= i_power_down_pin;
      pdb_s2 <= pdb_s1;
      pdb_d <= pdb_s2;
      remote_s1 <= i_remote_pin;
      remote_s2 <= remote_s1;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  // Mode field holds the strap value until software sets the override
  reg [2:0] mode;
  reg mode_ovr;
  reg [7:0] bc_mode;
  reg [7:0] clk_cfg;
  reg [4:0] hs_div;
  reg [7:0] local_pin_data;
  reg [7:0] pin_ctl;
  reg [7:0] pv_cfg;
  reg [7:0] pv_dt;
  wire pdb_rise = pdb_s2 & ~pdb_d;

  // Address compare shared by the write decode and the read mux
  function is_addr;
    input [7:0] a;
    input [7:0] b;
    begin
      is_addr = (a == b);
    end
  endfunction

  // All configuration registers share one write decode
  always @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      mode <= `SCMS_MODE_SYNC;
      mode_ovr <= 1'b0;
      bc_mode <= 8'h00;
      clk_cfg <= `SCMS_CLKCFG_RST;
      hs_div <= `SCMS_HSDIV_RST;
      local_pin_data <= 8'h00;
      pin_ctl <= `SCMS_PINCTL_RST;
      pv_cfg <= 8'h00;
      pv_dt <= 8'h00;
    end
    else
    begin
      // Strap capture wins over a software write in the same cycle
      if (pdb_rise)
        mode <= strap_s2;
      else if (i_reg_wr && is_addr(i_reg_addr, `SCMS_ADDR_MODE) && mode_ovr)
        mode <= i_reg_wdata[2:0];
      // The override bit itself is always writable; it gates only the mode field
      if (i_reg_wr)
      begin
        if (is_addr(i_reg_addr, `SCMS_ADDR_MODE))
          mode_ovr <= i_reg_wdata[`SCMS_OVR_BIT];
        else if (is_addr(i_reg_addr, `SCMS_ADDR_BCMODE))
          bc_mode <= i_reg_wdata;
        else if (is_addr(i_reg_addr, `SCMS_ADDR_CLKCFG))
          clk_cfg <= i_reg_wdata;
        else if (is_addr(i_reg_addr, `SCMS_ADDR_HSDIV))
          hs_div <= i_reg_wdata[4:0];
        else if (is_addr(i_reg_addr, `SCMS_ADDR_LOCAL))
          local_pin_data <= i_reg_wdata;
        else if (is_addr(i_reg_addr, `SCMS_ADDR_PINCTL))
          pin_ctl <= i_reg_wdata;
        else if (is_addr(i_reg_addr, `SCMS_ADDR_PVCFG))
          pv_cfg <= i_reg_wdata;
        else if (is_addr(i_reg_addr, `SCMS_ADDR_PVDT))
          pv_dt <= i_reg_wdata;
      end
    end
  end

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  // Read is always live: the addressed register appears one edge later
  always @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
      o_reg_rdata <= 8'h00;
    else if (is_addr(i_reg_addr, `SCMS_ADDR_MODE))
      o_reg_rdata <= {3'h0, mode_ovr, 1'b0, mode};
    else if (is_addr(i_reg_addr, `SCMS_ADDR_BCMODE))
      o_reg_rdata <= bc_mode;
    else if (is_addr(i_reg_addr, `SCMS_ADDR_CLKCFG))
      o_reg_rdata <= clk_cfg;
    else if (is_addr(i_reg_addr, `SCMS_ADDR_HSDIV))
      o_reg_rdata <= {3'h0, hs_div};
    else if (is_addr(i_reg_addr, `SCMS_ADDR_LOCAL))
      o_reg_rdata <= local_pin_data;
    else if (is_addr(i_reg_addr, `SCMS_ADDR_PINCTL))
      o_reg_rdata <= pin_ctl;
    else if (is_addr(i_reg_addr, `SCMS_ADDR_PVCFG))
      o_reg_rdata <= pv_cfg;
    else if (is_addr(i_reg_addr, `SCMS_ADDR_PVDT))
      o_reg_rdata <= pv_dt;
    else
      o_reg_rdata <= 8'h00;
  end

  // ----------------------------------------
  // Clocking decode
  // ----------------------------------------
  // Outputs are registered from this decode, so they trail a mode change by one edge
  // One compare per mode code, shared by the status flops and the sample timing
  function mode_is;
    input [2:0] m;
    input [2:0] code;
    begin
      mode_is = (m == code);
    end
  endfunction

  reg [1:0] next_src;
  reg [7:0] next_mult;

  always @*
  begin
    next_src = 2'h0;
    next_mult = `SCMS_MULT_SYNC;
    case (mode)
      `SCMS_MODE_NSEXT:
      begin
        next_src = 2'h1;
        next_mult = (clk_cfg[2:0] == `SCMS_DIV_X40) ? `SCMS_MULT_X40 : `SCMS_MULT_X80;
      end
      `SCMS_MODE_NSINT:
      begin
        // Source 2 is full-rate oscillator, 3 half-rate
        next_src = clk_cfg[`SCMS_OSC_BIT] ? 2'h2 : 2'h3;
        next_mult = `SCMS_MULT_X80;
      end
      `SCMS_MODE_PVEXT:
      begin
        next_src = 2'h1;
        next_mult = `SCMS_MULT_PV;
      end
      // Codes that name no mode here fall back to synchronous, the reset mode
      default:
      begin
        next_src = 2'h0;
        next_mult = `SCMS_MULT_SYNC;
      end
    endcase
  end

  // Sensor clock stays off in internal mode; no reference then reaches the sensor
  always @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_ref_source <= 2'h0;
      o_fc_multiplier <= `SCMS_MULT_SYNC;
      o_high_speed_divider <= `SCMS_HSDIV_RST;
      o_sensor_clk_en <= 1'b1;
      o_parallel_video_mode <= 1'b0;
      o_type_match_enable <= 1'b0;
      o_parallel_video_type_filter <= 8'h00;
    end
    else
    begin
      o_ref_source <= next_src;
      o_fc_multiplier <= next_mult;
      o_high_speed_divider <= hs_div;
      o_sensor_clk_en <= !mode_is(mode, `SCMS_MODE_NSINT);
      o_parallel_video_mode <= mode_is(mode, `SCMS_MODE_PVEXT);
      o_type_match_enable <= pv_cfg[`SCMS_MATCH_BIT];
      o_parallel_video_type_filter <= pv_dt;
    end
  end

  // ----------------------------------------
  // Back-channel sample tick
  // ----------------------------------------
  // Rate follows mode; real sampling is set by frame timing, so this is an approximation
  // A mode change needs no restart: a shorter limit simply fires on the next edge
  function [10:0] sample_limit;
    input [2:0] m;
    begin
      if (mode_is(m, `SCMS_MODE_SYNC))
        sample_limit = `SCMS_CNT_SYNC - 11'h001;
      else if (mode_is(m, `SCMS_MODE_PVEXT))
        sample_limit = `SCMS_CNT_PV - 11'h001;
      else
        sample_limit = `SCMS_CNT_NSYNC - 11'h001;
    end
  endfunction

  reg [10:0] smp_cnt;
  wire [10:0] smp_lim = sample_limit(mode);
  wire smp_tick = (smp_cnt >= smp_lim);

  always @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
      smp_cnt <= 11'h000;
    else if (smp_tick)
      smp_cnt <= 11'h000;
    else
      smp_cnt <= smp_cnt + 11'h001;
  end

  // ----------------------------------------
  // Pin output path
  // ----------------------------------------
  // Upper nibble of local data picks remote, lower nibble is the local level
  // Enable and level are registered together so both change on one edge
  wire [3:0] remote_sel = local_pin_data[7:4];
  wire [3:0] local_level = local_pin_data[3:0];
  wire [3:0] out_en = pin_ctl[7:4];
  reg [3:0] remote_hold;
  genvar g;

  generate
    for (g = 0; g < 4; g = g + 1)
    begin : pin_path
      always @(posedge i_sys_clk or posedge i_rst)
      begin
        if (i_rst)
        begin
          remote_hold[g] <= 1'b0;
          o_pin_out[g] <= 1'b0;
          o_pin_oe[g] <= 1'b0;
        end
        else
        begin
          // Held between ticks, so a slow sample rate never glitches the pin
          if (smp_tick)
            remote_hold[g] <= remote_s2[g];
          o_pin_oe[g] <= out_en[g];
          o_pin_out[g] <= remote_sel[g] ? remote_hold[g] : local_level[g];
        end
      end
    end
  endgenerate

endmodule // scms_clock_mode

// ===== testbench/scms_clock_mode_properties.sv
// Concurrent checks on the clock-mode block ports.
// Assumes binding into scms_clock_mode on one clock.
`timescale 1ns/1ps
`include "scms_defs.vh"
module scms_props (
  // Clock and reset
  input wire i_sys_clk,
  input wire i_rst,
  // Register port
  input wire i_reg_wr,
  input wire [7:0] i_reg_addr,
  input wire [7:0] i_reg_wdata,
  // Status
  input wire [1:0] o_ref_source,
  input wire [7:0] o_fc_multiplier,
  input wire [4:0] o_high_speed_divider,
  input wire o_sensor_clk_en,
  input wire o_parallel_video_mode,
  input wire o_type_match_enable,
  input wire [7:0] o_parallel_video_type_filter
);
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_rst);
  property p_sync;
    o_ref_source == 2'h0 |-> o_fc_multiplier == `SCMS_MULT_SYNC;
  endproperty
  a_sync: assert property (p_sync) else $error("sync rate wrong");
  property p_ext;
    o_ref_source == 2'h1 && !o_parallel_video_mode
      |-> o_fc_multiplier == `SCMS_MULT_X80 || o_fc_multiplier == `SCMS_MULT_X40;
  endproperty
  a_ext: assert property (p_ext) else $error("ext rate wrong");
  property p_osc;
    o_ref_source[1] |-> o_fc_multiplier == `SCMS_MULT_X80;
  endproperty
  a_osc: assert property (p_osc) else $error("osc rate wrong");
  property p_noclk;
    o_ref_source[1] |-> !o_sensor_clk_en;
  endproperty
  a_noclk: assert property (p_noclk) else $error("sensor clock on");
  property p_pv;
    o_parallel_video_mode |-> o_fc_multiplier == `SCMS_MULT_PV && o_ref_source == 2'h1;
  endproperty
  a_pv: assert property (p_pv) else $error("pv rate wrong");
  property p_div;
    i_reg_wr && i_reg_addr == `SCMS_ADDR_HSDIV
      |-> ##2 o_high_speed_divider == $past(i_reg_wdata[4:0], 2);
  endproperty
  a_div: assert property (p_div) else $error("divider not taken");
  property p_match;
    i_reg_wr && i_reg_addr == `SCMS_ADDR_PVCFG
      |-> ##2 o_type_match_enable == $past(i_reg_wdata[7], 2);
  endproperty
  a_match: assert property (p_match) else $error("match enable wrong");
  property p_dt;
    i_reg_wr && i_reg_addr == `SCMS_ADDR_PVDT
      |-> ##2 o_parallel_video_type_filter == $past(i_reg_wdata, 2);
  endproperty
  a_dt: assert property (p_dt) else $error("type filter wrong");
  c_pv: cover property (o_parallel_video_mode);
  c_half: cover property (o_ref_source == 2'h3);
  c_x40: cover property (o_fc_multiplier == `SCMS_MULT_X40);
endmodule // scms_props
bind scms_clock_mode scms_props u_props (
  .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_reg_wr(i_reg_wr),
  .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
  .o_ref_source(o_ref_source), .o_fc_multiplier(o_fc_multiplier),
  .o_high_speed_divider(o_high_speed_divider), .o_sensor_clk_en(o_sensor_clk_en),
  .o_parallel_video_mode(o_parallel_video_mode), .o_type_match_enable(o_type_match_enable),
  .o_parallel_video_type_filter(o_parallel_video_type_filter)
);

// ===== testbench/scms_bc_partner.sv
// Far-side model: delivers remote pin levels over the back channel.
// Assumes the bench commands the level to send.
`timescale 1ns/1ps
module scms_bc_partner (
  // Clock
  input wire i_sys_clk,
  // Commanded level
  input wire [3:0] i_level,
  // To the block
  output reg [3:0] o_remote_pin
);
  initial o_remote_pin = 4'h0;
  // Levels move only on the system clock edge, synchronous to it
  always @(posedge i_sys_clk)
    o_remote_pin <= i_level;
endmodule // scms_bc_partner

// ===== testbench/scms_clock_mode_tb.sv
// Self-checking bench for the clock-mode block.
// Assumes 100 MHz clock and the back-channel partner model.
`timescale 1ns/1ps
`include "scms_defs.vh"
module scms_clock_mode_tb;
  reg clk = 0, rst = 1, pdn = 1, wr = 0;
  reg [2:0] strap = 3'h0;
  reg [7:0] addr = 8'h00, wd = 8'h00;
  reg [3:0] lvl = 4'h0;
  wire [3:0] rem, pin, oe;
  wire [7:0] rdat, mult, pvdt;
  wire [1:0] src;
  wire [4:0] hsd;
  wire sce, pvm, tme;
  integer error_cnt = 0, checks = 0, cnt;
  always #5 clk = ~clk;
  scms_bc_partner bc (.i_sys_clk(clk), .i_level(lvl), .o_remote_pin(rem));
  scms_clock_mode uut (.i_sys_clk(clk), .i_rst(rst), .i_mode_strap(strap),
    .i_power_down_pin(pdn), .i_remote_pin(rem), .i_reg_wr(wr), .i_reg_addr(addr),
    .i_reg_wdata(wd), .o_reg_rdata(rdat), .o_pin_out(pin), .o_pin_oe(oe),
    .o_ref_source(src), .o_fc_multiplier(mult), .o_high_speed_divider(hsd),
    .o_sensor_clk_en(sce), .o_parallel_video_mode(pvm), .o_type_match_enable(tme),
    .o_parallel_video_type_filter(pvdt));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task chk(input string nm, input [7:0] s, input [7:0] e);
    begin
      checks = checks + 1;
      if (s !== e)
      begin
        error_cnt = error_cnt + 1;
        $display("BAD %s exp %h seen %h", nm, e, s);
      end
    end
  endtask
  task wrr(input [7:0] a, input [7:0] d);
    begin
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wd <= d;
      @(posedge clk);
      wr <= 1'b0;
    end
  endtask
  // Status outputs trail the write by two edges
  task st;
    begin
      repeat (2) @(posedge clk);
      #1;
    end
  endtask
  task rd(input [7:0] a, input [7:0] e);
    begin
      @(posedge clk);
      addr <= a;
      st;
      chk("rdata", rdat, e);
    end
  endtask
  task meas(input [3:0] v);
    begin
      lvl <= v;
      cnt = 0;
      while (pin !== v && cnt < 1400)
      begin
        @(posedge clk);
        cnt = cnt + 1;
      end
    end
  endtask
  // First change aligns to a tick, the second spans one full period
  task t_tick(input [7:0] m, input integer n);
    begin
      // First write sets the override, the second lands the mode
      wrr(`SCMS_ADDR_MODE, m);
      wrr(`SCMS_ADDR_MODE, m);
      meas(4'ha);
      meas(4'h5);
      chk("tick", {7'h00, cnt >= n - 3 && cnt <= n + 3}, 8'h01);
      $display("done tick %0d", n);
    end
  endtask
  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_mode;
    begin
      chk("hsdiv", {3'h0, hsd}, 8'h04);
      wrr(`SCMS_ADDR_MODE, 8'h05);
      rd(`SCMS_ADDR_MODE, 8'h00);
      wrr(`SCMS_ADDR_MODE, 8'h15);
      wrr(`SCMS_ADDR_MODE, 8'h15);
      rd(`SCMS_ADDR_MODE, 8'h15);
      chk("mult", mult, `SCMS_MULT_PV);
      $display("done mode");
    end
  endtask
  task t_clk;
    begin
      wrr(`SCMS_ADDR_MODE, 8'h12);
      st;
      chk("mult", mult, `SCMS_MULT_X80);
      chk("fc_margin", {7'h00, mult > 8'h40}, 8'h01);
      wrr(`SCMS_ADDR_CLKCFG, 8'h01);
      st;
      chk("mult", mult, `SCMS_MULT_X40);
      wrr(`SCMS_ADDR_MODE, 8'h13);
      st;
      chk("src", {6'h00, src}, 8'h03);
      chk("sclk", {7'h00, sce}, 8'h00);
      wrr(`SCMS_ADDR_CLKCFG, 8'h08);
      st;
      chk("src", {6'h00, src}, 8'h02);
      wrr(`SCMS_ADDR_MODE, 8'h10);
      wrr(`SCMS_ADDR_HSDIV, 8'h10);
      st;
      chk("mult", mult, `SCMS_MULT_SYNC);
      chk("fc_margin", {7'h00, mult > 8'h80}, 8'h01);
      chk("hsdiv", {3'h0, hsd}, 8'h10);
      $display("done clk");
    end
  endtask
  task t_regs;
    begin
      wrr(`SCMS_ADDR_BCMODE, 8'h5a);
      rd(`SCMS_ADDR_BCMODE, 8'h5a);
      wrr(`SCMS_ADDR_PVCFG, 8'h80);
      wrr(`SCMS_ADDR_PVDT, 8'h2b);
      st;
      chk("match", {7'h00, tme}, 8'h01);
      chk("dt", pvdt, 8'h2b);
      rd(8'h20, 8'h00);
      $display("done regs");
    end
  endtask
  task t_strap;
    begin
      wrr(`SCMS_ADDR_MODE, 8'h00);
      strap <= 3'h5;
      pdn <= 1'b0;
      repeat (4) @(posedge clk);
      pdn <= 1'b1;
      repeat (8) @(posedge clk);
      rd(`SCMS_ADDR_MODE, 8'h05);
      chk("pvm", {7'h00, pvm}, 8'h01);
      $display("done strap");
    end
  endtask
  task t_pin;
    begin
      wrr(`SCMS_ADDR_PINCTL, 8'hf0);
      wrr(`SCMS_ADDR_LOCAL, 8'h05);
      st;
      chk("oe", {4'h0, oe}, 8'h0f);
      chk("pin", {4'h0, pin}, 8'h05);
      wrr(`SCMS_ADDR_LOCAL, 8'hf0);
      t_tick(8'h10, 59);
      t_tick(8'h12, 299);
      t_tick(8'h15, 1197);
      $display("done pin");
    end
  endtask
  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_mode;
    t_clk;
    t_regs;
    t_strap;
    t_pin;
    give_verdict;
  end
  initial
  begin
    #400000;
    error_cnt = error_cnt + 1;
    give_verdict;
  end
endmodule // scms_clock_mode_tb
